// *** hw/duc_blank_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module duc_blank_timer
  import duc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_sync_b,
  input  wire logic       half_duplex,
  input  wire logic       tx_active,
  input  wire logic [7:0] steps,
  output logic            blank
);
  import duc_pkg::*;

  typedef enum logic [1:0] {BT_IDLE, BT_TX, BT_HOLD} duc_bt_state_t;

  duc_bt_state_t state_r, state_nxt;   // Blanking phase
  logic [11:0]   pre_r;                // Cycles left in current step
  logic [7:0]    left_r;               // Steps left to hold
  logic [7:0]    lim;                  // Steps clamped to the 10 ms ceiling

  // Values past the ceiling behave as the ceiling
  assign lim = (steps > TMO_MAX_STEPS) ? TMO_MAX_STEPS : steps;

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BT_IDLE: if (half_duplex && tx_active) state_nxt = BT_TX;
      BT_TX: begin
        if (!half_duplex) state_nxt = BT_IDLE;
        else if (!tx_active) state_nxt = (lim == 8'h00) ? BT_IDLE : BT_HOLD;
      end
      BT_HOLD: begin
        if (!half_duplex) state_nxt = BT_IDLE;
        else if (tx_active) state_nxt = BT_TX;
        else if (left_r == 8'h01 && pre_r == 12'h000) state_nxt = BT_IDLE;
      end
      default: state_nxt = BT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) state_r <= BT_IDLE;
    else state_r <= state_nxt;
  end

  // Step counters reload outside the hold phase
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pre_r  <= BLANK_STEP_LAST;
      left_r <= 8'h00;
    end else if (state_r != BT_HOLD) begin
      pre_r  <= BLANK_STEP_LAST;
      left_r <= lim;
    end else if (pre_r == 12'h000) begin
      pre_r  <= BLANK_STEP_LAST;
      left_r <= left_r - 8'h01;
    end else begin
      pre_r  <= pre_r - 12'h001;
    end
  end

  assign blank = (state_r != BT_IDLE);

  a_zero_step_end: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (state_r == BT_TX && half_duplex && !tx_active && lim == 8'h00) |=> !blank)
    else $error("zero timeout kept blanking after transmit");
  a_hold_bounded: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (state_r == BT_HOLD) |-> (left_r != 8'h00 && left_r <= TMO_MAX_STEPS))
    else $error("hold step count out of range");
endmodule

`default_nettype wire

// *** hw/duc_ir_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Infrared settings from the register file and blanking from the turnaround timer, passed to the pin path
interface duc_ir_if;
  logic rx_pol;     // Receive input active low
  logic tx_pol;     // Transmit output active low
  logic ir_on;      // IrDA protocol code selected
  logic alt_route;  // Use the alternate infrared pins
  logic blank;      // Receiver blanked for half duplex

  modport cfg (output rx_pol, output tx_pol, output ir_on, output alt_route, output blank);
  modport path (input rx_pol, input tx_pol, input ir_on, input alt_route, input blank);
endinterface

`default_nettype wire

// *** hw/duc_ir_path.sv ***
`timescale 1ns/1ps
`default_nettype none

module duc_ir_path (
  input  wire logic ref_clk,
  input  wire logic rst_sync_b,
  duc_ir_if.path    cfg,
  input  wire logic uart_tx_data,
  output logic      uart_rx_data,
  input  wire logic uart_two_rx_pin,
  input  wire logic alt_infrared_rx_pin,
  output logic      uart_two_tx_pin,
  output logic      alt_infrared_tx_pin
);
  logic [1:0] s1_r, s2_r;     // Pin synchronisers, bit 1 is the alternate pin
  logic       rx_sel, rx_dec, tx_line, tx_idle;

  // Two stages before any logic reads the pins
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
    end else begin
      s1_r <= {alt_infrared_rx_pin, uart_two_rx_pin};
      s2_r <= s1_r;
    end
  end

  // Light on the line stands for a zero bit in infrared modes
  assign rx_sel  = cfg.alt_route ? s2_r[1] : s2_r[0];
  assign rx_dec  = cfg.ir_on ? ~(rx_sel ^ cfg.rx_pol) : rx_sel;
  assign tx_line = cfg.ir_on ? (~uart_tx_data ^ cfg.tx_pol) : uart_tx_data;
  assign tx_idle = cfg.ir_on ? cfg.tx_pol : 1'b1;

  // Blanked receiver sees an idle line
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) uart_rx_data <= 1'b1;
    else uart_rx_data <= cfg.blank ? 1'b1 : rx_dec;
  end

  // Unused output rests at its idle level
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      uart_two_tx_pin     <= 1'b1;
      alt_infrared_tx_pin <= 1'b1;
    end else begin
      uart_two_tx_pin     <= cfg.alt_route ? tx_idle : tx_line;
      alt_infrared_tx_pin <= cfg.alt_route ? tx_line : tx_idle;
    end
  end
endmodule

`default_nettype wire

// *** hw/duc_pkg.sv ***
`default_nettype none

package duc_pkg;

  // ---------------------------------------------------------------
  // Register map: logical device in addr[11:8], index in addr[7:0]
  // ---------------------------------------------------------------
  localparam logic [3:0] LDN_SER_ONE   = 4'h4;   // First serial port
  localparam logic [3:0] LDN_SER_TWO   = 4'h5;   // Second serial port
  localparam logic [7:0] IDX_MODE      = 8'hF0;  // Serial mode register
  localparam logic [7:0] IDX_IR_OPT    = 8'hF1;  // Infrared options
  localparam logic [7:0] IDX_IR_TMO    = 8'hF2;  // Turnaround timeout
  localparam logic [7:0] IDX_STATUS    = 8'hF3;  // Live status, read only

  // ---------------------------------------------------------------
  // Values after hard reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_IR_OPT    = 8'h02;
  localparam logic [7:0] RST_IR_TMO    = 8'h03;

  // ---------------------------------------------------------------
  // Field positions and writable masks
  // ---------------------------------------------------------------
  localparam int         MODE_MIDI_BIT = 0;
  localparam int         MODE_HS_BIT   = 1;
  localparam int         MODE_SHARE_BIT = 7;
  localparam int         IR_RXPOL_BIT  = 0;
  localparam int         IR_TXPOL_BIT  = 1;
  localparam int         IR_DUPLEX_BIT = 2;
  localparam int         IR_MODE_LSB   = 3;
  localparam int         IR_MODE_MSB   = 5;
  localparam int         IR_ROUTE_BIT  = 6;
  localparam int         STAT_BLANK_BIT = 0;
  localparam int         STAT_IRQ1_BIT = 1;
  localparam int         STAT_IRQ2_BIT = 2;
  localparam logic [7:0] MODE1_WMASK   = 8'h83;  // Bits 6:2 kept at zero
  localparam logic [7:0] MODE2_WMASK   = 8'h03;  // Bits 7:2 kept at zero
  localparam logic [7:0] IR_OPT_WMASK  = 8'h7F;  // Bit 7 kept at zero
  localparam logic [2:0] IR_MODE_STD   = 3'h0;
  localparam logic [2:0] IR_MODE_IRDA  = 3'h1;

  // ---------------------------------------------------------------
  // Timing: 100 us blanking step, 10 ms ceiling, 40 ns clock
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         BLANK_STEP_NS = 100000;
  localparam int         BLANK_MAX_NS  = 10000000;
  localparam int         BLANK_STEP_CYC = BLANK_STEP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] BLANK_STEP_LAST = 12'(BLANK_STEP_CYC - 1);
  localparam logic [7:0] TMO_MAX_STEPS = 8'(BLANK_MAX_NS / BLANK_STEP_NS);

endpackage

`default_nettype wire

// *** hw/duc_top.sv ***
// Contract
// - Mode bit zero enables MIDI per port
// - Port one bit seven shares interrupts
// - Shared, both pins assert on either interrupt
// - Option bit zero inverts infrared receive
// - Option bit one inverts infrared transmit
// - Option bit two selects half duplex
// - Mode code zero standard, one infrared
// - Option bit six routes alternate pins
// - Timeout counts 100 us steps, 10 ms
// - Zero timeout blanks only during activity
// - Defaults load only on hard reset
// - Modem output bit low floats interrupt; shared pins float only when both are low
`timescale 1ns/1ps
`default_nettype none

module duc_top
  import duc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Register bus
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Interrupt requests and pin controls
  input  wire logic        uart_one_irq,
  input  wire logic        uart_two_irq,
  input  wire logic        aux_modem_output_one,
  input  wire logic        aux_modem_output_two,
  input  wire logic        uart_one_irq_assigned,
  input  wire logic        uart_two_irq_assigned,
  output logic             irq_one_out,
  output logic             irq_one_oe,
  output logic             irq_two_out,
  output logic             irq_two_oe,
  // Mode settings to the UART cores
  output logic             uart_one_midi,
  output logic             uart_one_high_speed,
  output logic             uart_two_midi,
  output logic             uart_two_high_speed,
  output logic             ir_half_duplex,
  output logic             ir_irda_mode,
  output logic             ir_mode_reserved,
  // Second port serial data and pins
  input  wire logic        uart_two_tx_data,
  input  wire logic        uart_two_tx_active,
  output logic             uart_two_rx_data,
  input  wire logic        uart_two_rx_pin,
  input  wire logic        alt_infrared_rx_pin,
  output logic             uart_two_tx_pin,
  output logic             alt_infrared_tx_pin
);
  import duc_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  // Raw rst_b reaches only the release pair
  logic [1:0] rst_pipe_r;   // Release synchroniser
  logic       rst_sync_b;   // Hard reset used everywhere below

  // Assert at once, release two edges later so no flop sees a runt release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) rst_pipe_r <= 2'h0;
    else rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_sync_b = rst_pipe_r[1];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Match one logical device and index
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [3:0]  ldn,
                                   input logic [7:0]  idx);
    reg_hit = (addr[11:8] == ldn) && (addr[7:0] == idx);
  endfunction

  // Status index has no write select, so writes to it drop
  logic wr_mode1, wr_mode2, wr_ir_opt, wr_ir_tmo;   // Write selects
  assign wr_mode1  = reg_wr && reg_hit(reg_addr, LDN_SER_ONE, IDX_MODE);
  assign wr_mode2  = reg_wr && reg_hit(reg_addr, LDN_SER_TWO, IDX_MODE);
  assign wr_ir_opt = reg_wr && reg_hit(reg_addr, LDN_SER_TWO, IDX_IR_OPT);
  assign wr_ir_tmo = reg_wr && reg_hit(reg_addr, LDN_SER_TWO, IDX_IR_TMO);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] mode1_r;    // serial_one_mode
  logic [7:0] mode2_r;    // serial_two_mode
  logic [7:0] ir_opt_r;   // infrared_options
  logic [7:0] ir_tmo_r;   // infrared_turnaround_timeout

  // A soft reset would need its own input; none exists
  // Only the hard reset loads defaults; no soft reset reaches these
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) mode1_r <= RST_MODE;
    else if (wr_mode1) mode1_r <= reg_wdata & MODE1_WMASK;
  end

  // Unused upper bits never store, so they read back as zero
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) mode2_r <= RST_MODE;
    else if (wr_mode2) mode2_r <= reg_wdata & MODE2_WMASK;
  end

  // Top bit is reserved and held at zero
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) ir_opt_r <= RST_IR_OPT;
    else if (wr_ir_opt) ir_opt_r <= reg_wdata & IR_OPT_WMASK;
  end

  // Full eight bits stored; the timer clamps at the ceiling
  // Values above the ceiling read back as written
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) ir_tmo_r <= RST_IR_TMO;
    else if (wr_ir_tmo) ir_tmo_r <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // Mode outputs to the UART cores
  // ---------------------------------------------------------------
  logic [2:0] ir_mode;     // Protocol field
  logic       share_irq;   // Common interrupt line selected

  // Straight register bits, no decode delay
  assign uart_one_midi       = mode1_r[MODE_MIDI_BIT];
  assign uart_two_midi       = mode2_r[MODE_MIDI_BIT];
  assign uart_one_high_speed = mode1_r[MODE_HS_BIT];
  assign uart_two_high_speed = mode2_r[MODE_HS_BIT];
  assign share_irq           = mode1_r[MODE_SHARE_BIT];
  assign ir_half_duplex      = ir_opt_r[IR_DUPLEX_BIT];
  assign ir_mode             = ir_opt_r[IR_MODE_MSB:IR_MODE_LSB];

  // Limitation: reserved codes get no infrared shaping
  // Reserved codes run as a plain UART and are flagged to the core
  assign ir_irda_mode     = (ir_mode == IR_MODE_IRDA);
  assign ir_mode_reserved = (ir_mode != IR_MODE_IRDA) && (ir_mode != IR_MODE_STD);

  // ---------------------------------------------------------------
  // Interrupt pin steering
  // ---------------------------------------------------------------
  logic src_one, src_two;         // Requests after modem output gating
  logic irq_one_nxt, irq_two_nxt; // Pin levels
  logic oe_one_nxt, oe_two_nxt;   // Pin drive enables

  // A port whose modem output bit is low contributes nothing
  assign src_one = uart_one_irq && aux_modem_output_one;
  assign src_two = uart_two_irq && aux_modem_output_two;

  // Limitation: shared pins drive while either aux bit is high
  // Shared mode merges both requests onto every assigned pin
  always_comb begin
    if (share_irq) begin
      irq_one_nxt = src_one || src_two;
      irq_two_nxt = src_one || src_two;
      oe_one_nxt  = uart_one_irq_assigned && (aux_modem_output_one || aux_modem_output_two);
      oe_two_nxt  = uart_two_irq_assigned && (aux_modem_output_one || aux_modem_output_two);
    end else begin
      irq_one_nxt = src_one;
      irq_two_nxt = src_two;
      oe_one_nxt  = uart_one_irq_assigned && aux_modem_output_one;
      oe_two_nxt  = uart_two_irq_assigned && aux_modem_output_two;
    end
  end

  // One cycle of latency buys clean pins
  // Registered so the pins never glitch on decode changes
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_one_out <= 1'b0;
      irq_two_out <= 1'b0;
      irq_one_oe  <= 1'b0;
      irq_two_oe  <= 1'b0;
    end else begin
      irq_one_out <= irq_one_nxt;
      irq_two_out <= irq_two_nxt;
      irq_one_oe  <= oe_one_nxt;
      irq_two_oe  <= oe_two_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Infrared path and half duplex blanking
  // ---------------------------------------------------------------
  duc_ir_if ir_bus ();    // Settings to the pin path
  logic     blank_w;      // Receiver blanked

  // Polarity and routing bits go straight to the path
  assign ir_bus.rx_pol    = ir_opt_r[IR_RXPOL_BIT];
  assign ir_bus.tx_pol    = ir_opt_r[IR_TXPOL_BIT];
  assign ir_bus.ir_on     = ir_irda_mode;
  assign ir_bus.alt_route = ir_opt_r[IR_ROUTE_BIT];
  assign ir_bus.blank     = blank_w;

  // Turnaround timer for half duplex
  duc_blank_timer u_blank (
    .ref_clk     (ref_clk),
    .rst_sync_b  (rst_sync_b),
    .half_duplex (ir_half_duplex),
    .tx_active   (uart_two_tx_active),
    .steps       (ir_tmo_r),
    .blank       (blank_w)
  );

  // Synchronisers, polarity and pin routing
  duc_ir_path u_path (
    .ref_clk             (ref_clk),
    .rst_sync_b          (rst_sync_b),
    .cfg                 (ir_bus),
    .uart_tx_data        (uart_two_tx_data),
    .uart_rx_data        (uart_two_rx_data),
    .uart_two_rx_pin     (uart_two_rx_pin),
    .alt_infrared_rx_pin (alt_infrared_rx_pin),
    .uart_two_tx_pin     (uart_two_tx_pin),
    .alt_infrared_tx_pin (alt_infrared_tx_pin)
  );

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  // Status is read only; writes to it fall through
  logic [7:0] status_w;    // Live state of the block
  logic [7:0] rdata_nxt;   // Selected read value

  always_comb begin
    status_w = 8'h00;
    status_w[STAT_BLANK_BIT] = blank_w;
    status_w[STAT_IRQ1_BIT]  = irq_one_out;
    status_w[STAT_IRQ2_BIT]  = irq_two_out;
  end

  // Strobe gating keeps idle read data at zero
  // Unmapped reads return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (reg_hit(reg_addr, LDN_SER_ONE, IDX_MODE)) rdata_nxt = mode1_r;
      else if (reg_hit(reg_addr, LDN_SER_TWO, IDX_MODE)) rdata_nxt = mode2_r;
      else if (reg_hit(reg_addr, LDN_SER_TWO, IDX_IR_OPT)) rdata_nxt = ir_opt_r;
      else if (reg_hit(reg_addr, LDN_SER_TWO, IDX_IR_TMO)) rdata_nxt = ir_tmo_r;
      else if (reg_hit(reg_addr, LDN_SER_TWO, IDX_STATUS)) rdata_nxt = status_w;
      else rdata_nxt = 8'h00;
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) reg_rdata <= 8'h00;
    else reg_rdata <= rdata_nxt;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Each label names the rule it guards in its comment
  // Port one MIDI follows write
  a_midi_one_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_mode1 |=> (uart_one_midi == $past(reg_wdata[MODE_MIDI_BIT])))
    else $error("port one MIDI bit did not follow write");

  // Port two speed follows write
  a_speed_two_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_mode2 |=> (uart_two_high_speed == $past(reg_wdata[MODE_HS_BIT])) && (mode2_r[7:2] == 6'h00))
    else $error("port two speed bit wrong after write");

  // Share bit follows write
  a_share_bit_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_mode1 |=> (share_irq == $past(reg_wdata[MODE_SHARE_BIT])) && (mode1_r[6:2] == 5'h00))
    else $error("share bit wrong after write");

  // Shared request reaches both pins
  a_shared_both_pins: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (share_irq && uart_one_irq_assigned && uart_two_irq_assigned && (src_one || src_two))
      |=> (irq_one_out && irq_two_out && irq_one_oe && irq_two_oe))
    else $error("shared interrupt did not reach both pins");

  // Modem output low floats the pin
  a_aux_off_float: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (!share_irq && !aux_modem_output_one) |=> !irq_one_oe)
    else $error("port one interrupt driven with modem output low");

  // Options stored less reserved bit
  a_ir_opt_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_ir_opt |=> (ir_opt_r == ($past(reg_wdata) & IR_OPT_WMASK)))
    else $error("infrared options not stored as written");

  // Protocol code decodes to IrDA
  a_irda_decode: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    ir_irda_mode |-> (ir_opt_r[5:3] == 3'h1) && !ir_mode_reserved)
    else $error("infrared protocol decode wrong");

  // Transmit keeps receiver idle
  a_tx_blanks_rx: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (ir_half_duplex && uart_two_tx_active)[*2] |=> uart_two_rx_data)
    else $error("receiver not blanked while transmitting");

  // Read data one cycle later
  a_read_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (reg_rd && reg_hit(reg_addr, LDN_SER_TWO, IDX_IR_TMO) && !reg_wr) |=> (reg_rdata == ir_tmo_r))
    else $error("timeout read data wrong");

  // Read data zero without strobe
  a_idle_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data stood without a read");

  // Port two MIDI follows write
  a_midi_two_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_mode2 |=> (uart_two_midi == $past(reg_wdata[MODE_MIDI_BIT])))
    else $error("port two MIDI bit did not follow write");

  // Separate lines keep each request apart
  a_plain_irq_two: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    !share_irq |=> (irq_two_out == $past(src_two))
      && (irq_two_oe == $past(uart_two_irq_assigned && aux_modem_output_two)))
    else $error("port two interrupt pin wrong when not shared");

  // Reserved codes never run as IrDA
  a_reserved_code: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    ir_mode_reserved |-> !ir_irda_mode && (ir_mode != IR_MODE_STD))
    else $error("reserved protocol code decoded wrongly");

  // Timeout stored as written
  a_tmo_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    wr_ir_tmo |=> (ir_tmo_r == $past(reg_wdata)))
    else $error("timeout not stored as written");

  // Shared pins float when both aux bits are low
  a_shared_aux_float: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
    (share_irq && !aux_modem_output_one && !aux_modem_output_two)
      |=> (!irq_one_oe && !irq_two_oe))
    else $error("shared interrupt pin driven with both modem outputs low");

endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import duc_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0;  // 25 MHz system clock
  logic        rst_b   = 1'b0;  // Hard reset, active low
  logic [11:0] addr    = 12'h000;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  rdata;
  logic        irq1 = 1'b0, irq2 = 1'b0, aux1 = 1'b0, aux2 = 1'b0, as1 = 1'b0, as2 = 1'b0;
  logic        o1, e1, o2, e2, midi1, hs1, midi2, hs2, hdx, irda, resv;
  logic        txd = 1'b1, txa = 1'b0, rxp = 1'b1, arxp = 1'b1;  // Idle line levels
  logic        rxd, txp, atxp;
  int          err_count  = 0;
  int          num_checks = 0;
  logic [7:0]  v;  // Current random register value

  always #20 ref_clk = ~ref_clk;

  duc_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .uart_one_irq(irq1), .uart_two_irq(irq2),
    .aux_modem_output_one(aux1), .aux_modem_output_two(aux2),
    .uart_one_irq_assigned(as1), .uart_two_irq_assigned(as2), .irq_one_out(o1),
    .irq_one_oe(e1), .irq_two_out(o2), .irq_two_oe(e2), .uart_one_midi(midi1),
    .uart_one_high_speed(hs1), .uart_two_midi(midi2), .uart_two_high_speed(hs2),
    .ir_half_duplex(hdx), .ir_irda_mode(irda), .ir_mode_reserved(resv),
    .uart_two_tx_data(txd), .uart_two_tx_active(txa), .uart_two_rx_data(rxd),
    .uart_two_rx_pin(rxp), .alt_infrared_rx_pin(arxp), .uart_two_tx_pin(txp),
    .alt_infrared_tx_pin(atxp));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Compare with case equality so unknowns never match
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Interrupt pins as {out1, oe1, out2, oe2}; a driven pin needs its own aux bit, or either aux bit when shared
  function automatic logic [3:0] irq_exp(input logic sh);
    logic a, b;
    a = irq1 & aux1;
    b = irq2 & aux2;
    if (sh) begin
      return {a | b, as1 & (aux1 | aux2), a | b, as2 & (aux1 | aux2)};
    end
    return {a, as1 & aux1, b, as2 & aux2};
  endfunction

  // Request only after the two-flop release has passed
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic defaults();
    rd_chk(12'h4F0, RST_MODE);
    rd_chk(12'h5F0, RST_MODE);
    rd_chk(12'h5F1, RST_IR_OPT);
    rd_chk(12'h5F2, RST_IR_TMO);
    chk({midi1, hs1, midi2, hs2, hdx, irda, resv, 1'b0}, 8'h00);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h0E32));
    do_reset();
    defaults();
    $display("test defaults done");
    // Random mode values; reserved bits must read back as zero
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr_reg(12'h4F0, v);
      rd_chk(12'h4F0, v & MODE1_WMASK);
      chk({6'h00, midi1, hs1}, {6'h00, v[0], v[1]});
      wr_reg(12'h5F0, v);
      rd_chk(12'h5F0, v & MODE2_WMASK);
      chk({6'h00, midi2, hs2}, {6'h00, v[0], v[1]});
    end
    wr_reg(12'h6F0, 8'hFF);
    rd_chk(12'h6F0, 8'h00);
    $display("test mode registers done");
    // Every protocol code, including the reserved ones
    for (int m = 0; m < 8; m++) begin
      wr_reg(12'h5F1, 8'(m << 3) | 8'h80);
      rd_chk(12'h5F1, 8'(m << 3));
      chk({6'h00, irda, resv}, {6'h00, 1'(m == 1), 1'(m > 1)});
    end
    $display("test protocol codes done");
    // Separate then shared interrupts with random pin inputs
    for (int s = 0; s < 2; s++) begin
      wr_reg(12'h4F0, {1'(s), 7'h00});
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 24; i++) begin
        @(posedge ref_clk);
        {irq1, irq2, aux1, aux2, as1, as2} <= 6'($urandom);
        @(posedge ref_clk);
        #1 chk({4'h0, o1, e1, o2, e2}, {4'h0, irq_exp(1'(s))});
      end
    end
    // Host order for sharing: one pin assigned, none on the other, then share
    wr_reg(12'h4F0, 8'h00);
    {irq1, irq2, aux1, aux2, as1, as2} <= 6'h16;
    wr_reg(12'h4F0, 8'h80);
    repeat (2) @(posedge ref_clk);
    #1 chk({4'h0, o1, e1, o2, e2}, {4'h0, irq_exp(1'b1)});
    rd_chk(12'h5F3, 8'h06);
    $display("test interrupts done");
    // Polarity, protocol and routing on the pin path, full duplex
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom) & 8'h4B;
      wr_reg(12'h5F1, v);
      @(posedge ref_clk);
      {txd, rxp, arxp} <= 3'($urandom);
      repeat (4) @(posedge ref_clk);
      #1 chk({6'h00, v[6] ? atxp : txp, v[6] ? txp : atxp},
             {6'h00, v[3] ? ~txd ^ v[1] : txd, v[3] ? v[1] : 1'b1});
      chk({7'h00, rxd}, {7'h00, v[3] ? ~((v[6] ? arxp : rxp) ^ v[0])
                                      : (v[6] ? arxp : rxp)});
    end
    $display("test pin path done");
    // Half duplex blanking with timeout zero and one step
    for (int t = 0; t < 2; t++) begin
      wr_reg(12'h5F2, 8'(t));
      wr_reg(12'h5F1, 8'h04);
      @(posedge ref_clk);
      rxp <= 1'b0;
      txa <= 1'b1;
      repeat (10) @(posedge ref_clk);
      #1 chk({6'h00, hdx, rxd}, 8'h03);
      @(posedge ref_clk);
      txa <= 1'b0;
      if (t == 1) begin
        // Still blanked ten cycles before the step ends
        repeat (BLANK_STEP_CYC - 10) @(posedge ref_clk);
        #1 chk({7'h00, rxd}, 8'h01);
        repeat (15) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      #1 chk({7'h00, rxd}, 8'h00);
    end
    $display("test blanking done");
    // Registers now differ from defaults; hard reset reloads them
    do_reset();
    defaults();
    $display("test second reset done");
    print_verdict();
  end

  // Tests need about 2900 cycles; cut a hang well after that
  initial begin
    #(40 * 20000);
    err_count++;
    print_verdict();
  end

endmodule

`default_nettype wire
